// [trace_qual_params.svh]
// constants for the bus trace qualifier
`ifndef TRACE_QUAL_PARAMS_SVH
`define TRACE_QUAL_PARAMS_SVH

// register word offsets (byte address = offset)
`define REG_CTRL        8'h00
`define REG_COUNT       8'h04
`define REG_ADDR_MASK   8'h08
`define REG_ADDR_ONE    8'h0c
`define REG_ADDR_TWO    8'h10
`define REG_EXT_CMP     8'h14
`define REG_OPC_SPAN    8'h18
`define REG_DELAY       8'h1c
`define REG_STATUS      8'h20
`define REG_RD_INDEX    8'h24
`define REG_RD_LO       8'h28
`define REG_RD_HI       8'h2c

// control field positions
`define CTRL_MODE_BIT   0
`define CTRL_MEM_LSB    1
`define CTRL_IO_BIT     3
`define CTRL_RANGE_BIT  4
`define CTRL_OPC_BIT    5
`define CTRL_RUN_BIT    6

// opcode span command fields
`define SPAN_UPPER_LSB  16
// the action flag rides in the ignored low nibble of the lower bound,
// so both bounds keep all twelve compared bits
`define SPAN_ACT_BIT    0

// reset values
`define RST_ADDR_MASK   16'hffff
`define RST_COUNT       11'h000
`define RST_EXT_CMP     8'h00
`define RST_DELAY       11'h000

// trace memory limits
`define LAST_INDEX      11'h7fe
`define MAX_COUNT       11'h7ff

`endif

// [trace_qual_pkg.sv]
// types for the bus trace qualifier
package trace_qual_pkg;

    typedef enum logic [1:0] {
        MEM_OFF,
        ANY_MEMORY_ACCESS,
        MEMORY_READ_CYCLE,
        MEMORY_WRITE_CYCLE
    } memory_trace_mode_e;

    typedef enum logic [2:0] {
        CYC_IDLE,
        INSTR_FETCH_CYCLE,
        CYC_MEM_READ,
        CYC_MEM_WRITE,
        CYC_IO
    } cycle_kind_e;

    typedef enum {
        TR_IDLE,
        TR_ARMED,
        TR_DELAY,
        TR_DONE
    } trace_state_e;

endpackage : trace_qual_pkg

// [opcode_span_table.sv]
// table of opcode spans with add and delete
`timescale 1ns/1ps
`include "trace_qual_params.svh"
module opcode_span_table
    import trace_qual_pkg::*;
#(
    parameter int SPANS = 8
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        cmd_valid,
    input  wire logic [15:0] lower,
    input  wire logic [15:0] upper,
    input  wire logic        add,
    input  wire logic [15:0] opcode,
    output logic             hit
);
    initial begin
        if (SPANS < 1 || SPANS > 64) $error("SPANS out of range");
    end

    logic [11:0] lo_q [SPANS];
    logic [11:0] hi_q [SPANS];
    logic [SPANS-1:0] used_q;
    logic [SPANS-1:0] match;
    logic [SPANS-1:0] same;
    logic [SPANS-1:0] first_free;

    // free slot priority: lowest index wins
    assign first_free = ~used_q & (used_q + {{(SPANS-1){1'b0}}, 1'b1});

    genvar i;
    generate
        for (i = 0; i < SPANS; i++) begin : g_span
            assign match[i] = used_q[i] && opcode[15:4] >= lo_q[i]
                              && opcode[15:4] <= hi_q[i];
            assign same[i]  = used_q[i] && lo_q[i] == lower[15:4]
                              && hi_q[i] == upper[15:4];
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    used_q[i] <= 1'b0;
                    lo_q[i]   <= 12'h000;
                    hi_q[i]   <= 12'h000;
                end else if (cmd_valid && !add && same[i]) begin
                    used_q[i] <= 1'b0;
                end else if (cmd_valid && add && first_free[i] && same == '0) begin
                    used_q[i] <= 1'b1;
                    lo_q[i]   <= lower[15:4];
                    hi_q[i]   <= upper[15:4];
                end
            end
        end
    endgenerate

    assign hit = |match;
endmodule : opcode_span_table

// [trace_store.sv]
// trace sample memory, oldest sample at index zero
`timescale 1ns/1ps
`include "trace_qual_params.svh"
module trace_store
    import trace_qual_pkg::*;
#(
    parameter int WIDTH = 43,
    parameter int DEPTH = 2047
) (
    input  wire logic             clk,
    input  wire logic             wr_en,
    input  wire logic [10:0]      wr_index,
    input  wire logic [WIDTH-1:0] wr_data,
    input  wire logic [10:0]      rd_index,
    output logic      [WIDTH-1:0] rd_data
);
    initial begin
        if (DEPTH < 2 || DEPTH > 2048) $error("DEPTH out of range");
    end

    logic [WIDTH-1:0] mem [DEPTH];

    // synchronous read keeps it a block ram
    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_index] <= wr_data;
        end
        rd_data <= mem[rd_index];
    end
endmodule : trace_store

// [bus_trace_qualifier.sv]
// bus cycle trace qualifier with register port and trace memory
//
// How it works
// - the memory qualifier is off, any access, reads only or writes only.
// - in extended mode with any-access, every memory cycle of a qualifying fetch is stored.
// - with the range flag set, the two trace addresses are inclusive range bounds.
// - opcode spans compare fetched opcodes ignoring their low four bits.
// - a span command with action 1 adds a span and with action 0 removes it.
// - with opcode qualification on, a fetch qualifies only inside a span and the address test.
// - the sample count runs 1 to 7ff and zero means unlimited.
// - the mode bit picks basic memory and io tracing (0) or instruction tracing (1).
// - a 16-bit address mask enables comparison of each address bit set to one.
// - the io qualifier is off or accepts io accesses that pass the address and external tests.
// - the external byte is compared to a compare byte on the mask-enabled bits only.
// - samples are indexed from zero for the oldest and readable up to 7fe.
// - after the count ends, capture continues for the delay count, then stops.
`timescale 1ns/1ps
`include "trace_qual_params.svh"
module bus_trace_qualifier
    import trace_qual_pkg::*;
#(
    parameter int SPANS = 8
) (
    input  wire logic        REF_CLK,
    input  wire logic        RESET,
    input  wire logic [7:0]  ADDR,
    input  wire logic [31:0] WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic      [31:0] RDATA,
    input  wire logic        CYC_VALID,
    input  wire logic [2:0]  CYC_KIND,
    input  wire logic [15:0] CYC_ADDR,
    input  wire logic [15:0] CYC_DATA,
    input  wire logic [7:0]  EXTERNAL_QUALIFIER_BITS,
    output logic             TRACE_ACTIVE,
    output logic             TRACE_HALT
);
    localparam int DEPTH = 2047;
    localparam int WIDTH = 43;

    logic               instr_qualified_trace_q;
    memory_trace_mode_e memory_trace_mode_q;
    logic               io_trace_mode_q;
    logic               range_q;
    logic               opc_en_q;
    logic               run_q;
    logic [10:0]        count_q;
    logic [10:0]        delay_q;
    logic [15:0]        mask_q;
    logic [15:0]        addr_one_q;
    logic [15:0]        addr_two_q;
    logic [7:0]         ext_cmp_q;
    logic [7:0]         ext_mask_q;
    logic [10:0]        rd_index_q;
    trace_state_e       state_q;
    logic [10:0]        left_q;
    logic [10:0]        wr_index_q;
    logic [11:0]        stored_q;
    logic               in_fetch_q;
    logic               fetch_ok_q;
    logic [10:0]        rd_index_d;

    function automatic logic is_reg(input logic [7:0] a, input logic [7:0] r);
        return a == r;
    endfunction : is_reg

    // settings writes assumed only while stopped
    always_ff @(posedge REF_CLK or posedge RESET) begin
        if (RESET) begin
            instr_qualified_trace_q <= 1'b0;
            memory_trace_mode_q     <= MEM_OFF;
            io_trace_mode_q         <= 1'b0;
            range_q                 <= 1'b0;
            opc_en_q                <= 1'b0;
            count_q                 <= `RST_COUNT;
            mask_q                  <= `RST_ADDR_MASK;
            addr_one_q              <= 16'h0000;
            addr_two_q              <= 16'h0000;
            ext_cmp_q               <= `RST_EXT_CMP;
            ext_mask_q              <= 8'h00;
            delay_q                 <= `RST_DELAY;
            rd_index_q              <= 11'h000;
        end else if (WR) begin
            if (is_reg(ADDR, `REG_CTRL)) begin
                instr_qualified_trace_q <= WDATA[`CTRL_MODE_BIT];
                memory_trace_mode_q <= memory_trace_mode_e'(WDATA[`CTRL_MEM_LSB +: 2]);
                io_trace_mode_q <= WDATA[`CTRL_IO_BIT];
                range_q         <= WDATA[`CTRL_RANGE_BIT];
                opc_en_q        <= WDATA[`CTRL_OPC_BIT];
            end else if (is_reg(ADDR, `REG_COUNT)) begin
                count_q <= WDATA[10:0];
            end else if (is_reg(ADDR, `REG_ADDR_MASK)) begin
                mask_q <= WDATA[15:0];
            end else if (is_reg(ADDR, `REG_ADDR_ONE)) begin
                addr_one_q <= WDATA[15:0];
            end else if (is_reg(ADDR, `REG_ADDR_TWO)) begin
                addr_two_q <= WDATA[15:0];
            end else if (is_reg(ADDR, `REG_EXT_CMP)) begin
                ext_cmp_q  <= WDATA[7:0];
                ext_mask_q <= WDATA[15:8];
            end else if (is_reg(ADDR, `REG_DELAY)) begin
                delay_q <= WDATA[10:0];
            end else if (is_reg(ADDR, `REG_RD_INDEX)) begin
                // index clipped to the last sample
                rd_index_q <= (WDATA[10:0] > `LAST_INDEX) ? `LAST_INDEX : WDATA[10:0];
            end
        end
    end

    logic span_hit;
    opcode_span_table #(
        .SPANS (SPANS)
    ) u_spans (
        .clk       (REF_CLK),
        .rst       (RESET),
        .cmd_valid (WR && is_reg(ADDR, `REG_OPC_SPAN)),
        .lower     (WDATA[15:0]),
        .upper     (WDATA[`SPAN_UPPER_LSB +: 16]),
        .add       (WDATA[`SPAN_ACT_BIT]),
        .opcode    (CYC_DATA),
        .hit       (span_hit)
    );

    // qualification terms
    logic addr_ok;
    logic ext_ok;
    logic is_fetch;
    logic is_mem;
    logic fetch_qual;
    logic mem_qual;
    logic io_qual;
    logic take;
    logic [15:0] masked_addr;

    always_comb begin
        masked_addr = CYC_ADDR & mask_q;
        if (range_q) begin
            addr_ok = masked_addr >= (addr_one_q & mask_q)
                      && masked_addr <= (addr_two_q & mask_q);
        end else begin
            addr_ok = masked_addr == (addr_one_q & mask_q)
                      || masked_addr == (addr_two_q & mask_q);
        end
    end

    assign ext_ok   = ((EXTERNAL_QUALIFIER_BITS ^ ext_cmp_q) & ext_mask_q) == 8'h00;
    assign is_fetch = CYC_KIND == INSTR_FETCH_CYCLE;
    assign is_mem   = is_fetch || CYC_KIND == CYC_MEM_READ || CYC_KIND == CYC_MEM_WRITE;
    // fetch needs address and external match, plus a span hit when opcode qualification is on
    assign fetch_qual = is_fetch && addr_ok && ext_ok && (!opc_en_q || span_hit);

    always_comb begin
        case (memory_trace_mode_q)
            ANY_MEMORY_ACCESS:  mem_qual = is_mem;
            MEMORY_READ_CYCLE:  mem_qual = is_fetch || CYC_KIND == CYC_MEM_READ;
            MEMORY_WRITE_CYCLE: mem_qual = CYC_KIND == CYC_MEM_WRITE;
            default:            mem_qual = 1'b0;
        endcase
    end

    assign io_qual = io_trace_mode_q && CYC_KIND == CYC_IO && addr_ok && ext_ok;

    always_comb begin
        take = 1'b0;
        if (CYC_VALID) begin
            if (instr_qualified_trace_q) begin
                if (is_fetch) begin
                    take = fetch_qual && memory_trace_mode_q != MEM_OFF;
                end else if (is_mem) begin
                    take = in_fetch_q && fetch_ok_q && memory_trace_mode_q == ANY_MEMORY_ACCESS;
                end
            end else begin
                take = (mem_qual && addr_ok && ext_ok && !(is_fetch && opc_en_q && !span_hit))
                       || io_qual;
            end
        end
    end

    // a fetch opens a window that lasts until the next fetch
    always_ff @(posedge REF_CLK or posedge RESET) begin
        if (RESET) begin
            in_fetch_q <= 1'b0;
            fetch_ok_q <= 1'b0;
        end else if (CYC_VALID && is_fetch) begin
            in_fetch_q <= 1'b1;
            fetch_ok_q <= fetch_qual;
        end
    end

    logic capturing;
    logic store;
    assign capturing = state_q == TR_ARMED || state_q == TR_DELAY;
    assign store     = capturing && take && wr_index_q <= `LAST_INDEX;

    logic start_cmd;
    logic stop_cmd;
    assign start_cmd = WR && is_reg(ADDR, `REG_CTRL) && WDATA[`CTRL_RUN_BIT];
    assign stop_cmd  = WR && is_reg(ADDR, `REG_CTRL) && !WDATA[`CTRL_RUN_BIT];

    always_ff @(posedge REF_CLK or posedge RESET) begin
        if (RESET) begin
            state_q    <= TR_IDLE;
            left_q     <= 11'h000;
            wr_index_q <= 11'h000;
            stored_q   <= 12'h000;
            run_q      <= 1'b0;
        end else if (start_cmd) begin
            state_q    <= TR_ARMED;
            left_q     <= count_q;
            wr_index_q <= 11'h000;
            stored_q   <= 12'h000;
            run_q      <= 1'b1;
        end else if (stop_cmd) begin
            state_q <= TR_IDLE;
            run_q   <= 1'b0;
        end else begin
            if (store) begin
                wr_index_q <= wr_index_q + 11'h001;
                stored_q   <= stored_q + 12'h001;
            end
            case (state_q)
                TR_ARMED: begin
                    if (store && count_q != 11'h000) begin
                        if (left_q == 11'h001) begin
                            state_q <= (delay_q == 11'h000) ? TR_DONE : TR_DELAY;
                            left_q  <= delay_q;
                        end else begin
                            left_q <= left_q - 11'h001;
                        end
                    end
                end
                TR_DELAY: begin
                    if (store) begin
                        if (left_q == 11'h001) begin
                            state_q <= TR_DONE;
                        end
                        left_q <= left_q - 11'h001;
                    end
                end
                TR_DONE:  run_q <= 1'b0;
                default:  ;
            endcase
        end
    end

    // sample layout: kind, address, data, external bits
    logic [WIDTH-1:0] rd_sample;
    trace_store #(
        .WIDTH (WIDTH),
        .DEPTH (DEPTH)
    ) u_store (
        .clk      (REF_CLK),
        .wr_en    (store),
        .wr_index (wr_index_q),
        .wr_data  ({CYC_KIND, CYC_ADDR, CYC_DATA, EXTERNAL_QUALIFIER_BITS}),
        .rd_index (rd_index_d),
        .rd_data  (rd_sample)
    );

    always_ff @(posedge REF_CLK or posedge RESET) begin
        if (RESET) begin
            TRACE_ACTIVE <= 1'b0;
            TRACE_HALT   <= 1'b0;
        end else begin
            TRACE_ACTIVE <= capturing;
            TRACE_HALT   <= state_q == TR_DONE;
        end
    end

    // new index reaches the memory at once, so a read right after the write sees it
    always_comb begin
        rd_index_d = rd_index_q;
        if (WR && is_reg(ADDR, `REG_RD_INDEX)) begin
            rd_index_d = (WDATA[10:0] > `LAST_INDEX) ? `LAST_INDEX : WDATA[10:0];
        end
    end

    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (ADDR == `REG_CTRL) begin
            rd_mux = {25'h0, run_q, opc_en_q, range_q, io_trace_mode_q,
                      memory_trace_mode_q, instr_qualified_trace_q};
        end else if (ADDR == `REG_COUNT) begin
            rd_mux = {21'h0, count_q};
        end else if (ADDR == `REG_ADDR_MASK) begin
            rd_mux = {16'h0, mask_q};
        end else if (ADDR == `REG_ADDR_ONE) begin
            rd_mux = {16'h0, addr_one_q};
        end else if (ADDR == `REG_ADDR_TWO) begin
            rd_mux = {16'h0, addr_two_q};
        end else if (ADDR == `REG_EXT_CMP) begin
            rd_mux = {16'h0, ext_mask_q, ext_cmp_q};
        end else if (ADDR == `REG_DELAY) begin
            rd_mux = {21'h0, delay_q};
        end else if (ADDR == `REG_STATUS) begin
            rd_mux = {8'h0, left_q, stored_q, run_q};
        end else if (ADDR == `REG_RD_INDEX) begin
            rd_mux = {21'h0, rd_index_q};
        end else if (ADDR == `REG_RD_LO) begin
            rd_mux = rd_sample[31:0];
        end else if (ADDR == `REG_RD_HI) begin
            rd_mux = {21'h0, rd_sample[42:32]};
        end
    end

    // read data is registered so it stands only in the cycle after the strobe
    always_ff @(posedge REF_CLK or posedge RESET) begin
        if (RESET) begin
            RDATA <= 32'h0000_0000;
        end else begin
            RDATA <= RD ? rd_mux : 32'h0000_0000;
        end
    end
endmodule : bus_trace_qualifier

// [bus_trace_checker.sv]
// port assertions for the bus trace qualifier
`timescale 1ns/1ps
`include "trace_qual_params.svh"
module bus_trace_checker
    import trace_qual_pkg::*;
#(
    parameter int SPANS = 8
) (
    input wire logic        REF_CLK,
    input wire logic        RESET,
    input wire logic [7:0]  ADDR,
    input wire logic [31:0] WDATA,
    input wire logic        WR,
    input wire logic        RD,
    input wire logic [31:0] RDATA,
    input wire logic        CYC_VALID,
    input wire logic [2:0]  CYC_KIND,
    input wire logic [15:0] CYC_ADDR,
    input wire logic [15:0] CYC_DATA,
    input wire logic [7:0]  EXTERNAL_QUALIFIER_BITS,
    input wire logic        TRACE_ACTIVE,
    input wire logic        TRACE_HALT
);
    // last value written to each setting; slot 6 is the write-only span command
    logic [15:0] shadow_q [0:7];

    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (RESET);

    always_ff @(posedge REF_CLK or posedge RESET) begin
        if (RESET) begin
            for (int i = 0; i < 8; i++) begin
                shadow_q[i] <= (i == 2) ? `RST_ADDR_MASK : 16'h0000;
            end
        end else if (WR && ADDR[7:5] == 3'h0 && ADDR[1:0] == 2'h0) begin
            shadow_q[ADDR[4:2]] <= WDATA[15:0];
        end
    end

    ctrl_readback_a: assert property (
        RD && ADDR == `REG_CTRL |=> RDATA[5:0] == shadow_q[0][5:0])
        else $error("control setting reads back wrong");
    count_readback_a: assert property (
        RD && ADDR == `REG_COUNT |=> RDATA[10:0] == shadow_q[1][10:0])
        else $error("sample count reads back wrong");
    mask_readback_a: assert property (
        RD && ADDR == `REG_ADDR_MASK |-> ##1 RDATA[15:0] == shadow_q[2])
        else $error("address mask reads back wrong");
    bound_one_a: assert property (
        RD && ADDR == `REG_ADDR_ONE |=> RDATA[15:0] == shadow_q[3])
        else $error("first trace address reads back wrong");
    bound_two_a: assert property (
        RD && ADDR == `REG_ADDR_TWO |=> RDATA[15:0] == shadow_q[4])
        else $error("second trace address reads back wrong");
    ext_compare_a: assert property (
        RD && ADDR == `REG_EXT_CMP |=> RDATA[15:0] == shadow_q[5])
        else $error("compare byte and mask read back wrong");
    delay_readback_a: assert property (
        RD && ADDR == `REG_DELAY |=> RDATA[10:0] == shadow_q[7][10:0])
        else $error("delay count reads back wrong");
    halt_sticky_a: assert property (
        $fell(TRACE_HALT) |-> $past(WR && ADDR == `REG_CTRL, 2))
        else $error("halt dropped without a control write");
    halt_excl_a: assert property (
        !(TRACE_ACTIVE && TRACE_HALT))
        else $error("capturing while halted");
endmodule : bus_trace_checker

bind bus_trace_qualifier bus_trace_checker #(.SPANS(SPANS)) checker_i (
    .REF_CLK(REF_CLK), .RESET(RESET), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .CYC_VALID(CYC_VALID), .CYC_KIND(CYC_KIND), .CYC_ADDR(CYC_ADDR),
    .CYC_DATA(CYC_DATA), .EXTERNAL_QUALIFIER_BITS(EXTERNAL_QUALIFIER_BITS),
    .TRACE_ACTIVE(TRACE_ACTIVE), .TRACE_HALT(TRACE_HALT)
);

// [target_bus_model.sv]
// target processor bus model, one bus cycle per request
`timescale 1ns/1ps
module target_bus_model
    import trace_qual_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        go,
    input  wire logic [2:0]  kind,
    input  wire logic [15:0] addr,
    input  wire logic [15:0] data,
    input  wire logic [7:0]  ext,
    output logic             valid_q,
    output logic      [2:0]  kind_q,
    output logic      [15:0] addr_q,
    output logic      [15:0] data_q,
    output logic      [7:0]  ext_q
);
    // between cycles the lines toggle so a stale value can never pass for a new one
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            valid_q <= 1'b0;
            kind_q  <= CYC_IDLE;
            {addr_q, data_q, ext_q} <= 40'h0;
        end else if (go) begin
            valid_q <= 1'b1;
            kind_q  <= kind;
            {addr_q, data_q, ext_q} <= {addr, data, ext};
        end else begin
            valid_q <= 1'b0;
            kind_q  <= CYC_IDLE;
            {addr_q, data_q, ext_q} <= ~{addr_q, data_q, ext_q};
        end
    end
endmodule : target_bus_model

// [tb_bus_trace_qualifier.sv]
// self-checking bench for the bus trace qualifier
`timescale 1ns/1ps
`include "trace_qual_params.svh"
module tb_bus_trace_qualifier
    import trace_qual_pkg::*;
;
    logic        clk, rst, wr_s, rd_s, go, valid, active, halt;
    logic [7:0]  bus_a, ext, c_ext;
    logic [31:0] wdata, rdata, d;
    logic [2:0]  kind, c_kind;
    logic [15:0] addr, data, c_addr, c_data;
    logic [42:0] exp_q [$];
    int          n_fail, compares;

    bus_trace_qualifier dut (
        .REF_CLK(clk), .RESET(rst), .ADDR(bus_a), .WDATA(wdata), .WR(wr_s), .RD(rd_s),
        .RDATA(rdata), .CYC_VALID(valid), .CYC_KIND(c_kind), .CYC_ADDR(c_addr),
        .CYC_DATA(c_data), .EXTERNAL_QUALIFIER_BITS(c_ext),
        .TRACE_ACTIVE(active), .TRACE_HALT(halt)
    );
    target_bus_model target (
        .clk(clk), .rst(rst), .go(go), .kind(kind), .addr(addr), .data(data), .ext(ext),
        .valid_q(valid), .kind_q(c_kind), .addr_q(c_addr), .data_q(c_data), .ext_q(c_ext)
    );

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic final_report;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : final_report

    // each access holds one cycle, then lets an edge pass before the next
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        {wr_s, rd_s, go} <= 3'h4;
        {bus_a, wdata} <= {a, v};
        @(posedge clk);
        wr_s <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk);
        {wr_s, rd_s, go} <= 3'h2;
        bus_a <= a;
        @(posedge clk);
        rd_s <= 1'b0;
        #1 v = rdata;
    endtask : rd

    task automatic cy(input logic [2:0] k, input logic [15:0] a, input logic [15:0] v,
                      input logic [7:0] e, input logic keep);
        @(posedge clk);
        {wr_s, rd_s, go} <= 3'h1;
        {kind, addr, data, ext} <= {k, a, v, e};
        if (keep) exp_q.push_back({k, a, v, e});
        @(posedge clk);
        go <= 1'b0;
    endtask : cy

    task automatic rdc(input logic [15:0] a, input logic [7:0] e, input logic keep);
        cy(CYC_MEM_READ, a, ~a, e, keep);
    endtask : rdc

    task automatic start(input logic [31:0] c);
        wr(`REG_CTRL, c | 32'h40);
        repeat (2) @(posedge clk);
        chk({31'h0, active}, 32'h1);
    endtask : start

    // stop, then every stored sample must match in order, oldest first
    task automatic fin(input logic [31:0] c);
        repeat (3) @(posedge clk);
        wr(`REG_CTRL, c);
        rd(`REG_STATUS, d);
        chk(32'(d[12:1]), 32'(exp_q.size()));
        for (int i = 0; i < exp_q.size(); i++) begin
            wr(`REG_RD_INDEX, 32'(i));
            rd(`REG_RD_LO, d);
            chk(d, exp_q[i][31:0]);
            rd(`REG_RD_HI, d);
            chk({21'h0, d[10:0]}, {21'h0, exp_q[i][42:32]});
        end
        exp_q.delete();
    endtask : fin

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    initial begin
        repeat (60000) @(posedge clk);
        n_fail++;
        $display("ERROR %0t watchdog expired", $time);
        final_report;
    end

    initial begin
        {wr_s, rd_s, go, bus_a, wdata} = 43'h0;
        {kind, addr, data, ext} = 43'h0;
        rst = 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            rd(8'(i * 4), d);
            if (i != 6) chk(d, (i == 2) ? 32'h0000ffff : 32'h0);
        end
        wr(8'h30, 32'hffff_ffff);
        rd(8'h30, d);
        chk(d, 32'h0);
        wr(`REG_COUNT, 32'h7ff);
        rd(`REG_COUNT, d);
        chk(d, 32'h7ff);
        wr(`REG_COUNT, 32'h0);
        wr(`REG_ADDR_TWO, 32'hffff);
        // basic mode, every memory and io qualifier setting
        for (int m = 0; m < 8; m++) begin
            start({27'h1, m[2], m[1:0], 1'b0});
            cy(CYC_MEM_READ, 16'h0100, 16'h1111, 8'h01, m[1:0] inside {1, 2});
            cy(CYC_MEM_WRITE, 16'h0102, 16'h2222, 8'h02, m[1:0] inside {1, 3});
            cy(CYC_IO, 16'h0040, 16'h3333, 8'h03, m[2]);
            fin({27'h1, m[2], m[1:0], 1'b0});
        end
        // inclusive range edges
        wr(`REG_ADDR_ONE, 32'h16);
        wr(`REG_ADDR_TWO, 32'h1c);
        start(32'h12);
        rdc(16'h0015, 8'h11, 1'b0);
        rdc(16'h0016, 8'h12, 1'b1);
        rdc(16'h001c, 8'h13, 1'b1);
        rdc(16'h001d, 8'h14, 1'b0);
        fin(32'h12);
        // masked exact match on either address
        wr(`REG_ADDR_MASK, 32'hfff0);
        wr(`REG_ADDR_ONE, 32'h1230);
        wr(`REG_ADDR_TWO, 32'h4560);
        start(32'h02);
        rdc(16'h123f, 8'h21, 1'b1);
        rdc(16'h1240, 8'h22, 1'b0);
        rdc(16'h456a, 8'h23, 1'b1);
        fin(32'h02);
        wr(`REG_ADDR_MASK, 32'hffff);
        wr(`REG_ADDR_ONE, 32'h0);
        wr(`REG_ADDR_TWO, 32'hffff);
        wr(`REG_EXT_CMP, 32'h0f05);
        start(32'h12);
        rdc(16'h0200, 8'ha5, 1'b1);
        rdc(16'h0202, 8'h56, 1'b0);
        rdc(16'h0204, 8'h05, 1'b1);
        fin(32'h12);
        wr(`REG_EXT_CMP, 32'h0);
        // instruction tracing through one opcode span
        wr(`REG_OPC_SPAN, 32'h0430_0401);
        start(32'h33);
        cy(INSTR_FETCH_CYCLE, 16'h0000, 16'h1000, 8'hff, 1'b0);
        cy(CYC_MEM_READ, 16'h0004, 16'h000a, 8'hff, 1'b0);
        cy(INSTR_FETCH_CYCLE, 16'h0002, 16'h0420, 8'hff, 1'b1);
        cy(CYC_MEM_READ, 16'h000a, 16'h0014, 8'hff, 1'b1);
        cy(CYC_MEM_WRITE, 16'h002e, 16'h0040, 8'hff, 1'b1);
        cy(INSTR_FETCH_CYCLE, 16'h0008, 16'h043f, 8'hff, 1'b1);
        cy(INSTR_FETCH_CYCLE, 16'h000c, 16'h0440, 8'hff, 1'b0);
        cy(CYC_MEM_WRITE, 16'h0030, 16'h0006, 8'hff, 1'b0);
        cy(INSTR_FETCH_CYCLE, 16'h000e, 16'h03ff, 8'hff, 1'b0);
        fin(32'h33);
        wr(`REG_OPC_SPAN, 32'h0430_0400);
        start(32'h33);
        cy(INSTR_FETCH_CYCLE, 16'h0002, 16'h0420, 8'hff, 1'b0);
        fin(32'h33);
        // count of three, then two more samples before the halt
        wr(`REG_COUNT, 32'h3);
        wr(`REG_DELAY, 32'h2);
        start(32'h12);
        for (int i = 0; i < 8; i++) rdc(16'(i), 8'h00, i < 5);
        repeat (3) @(posedge clk);
        chk({30'h0, active, halt}, 32'h1);
        fin(32'h12);
        // unlimited count fills the memory up to its last index
        wr(`REG_COUNT, 32'h0);
        wr(`REG_DELAY, 32'h0);
        start(32'h12);
        for (int i = 0; i < 2050; i++) rdc(16'(i), 8'h00, i < 2047);
        fin(32'h12);
        final_report;
    end
endmodule : tb_bus_trace_qualifier
